// file: hdla_arbiter.sv
`timescale 1ns/100ps

module hdla_fifo
    import hdla_pkg::*;
#(
    parameter int unsigned WIDTH = 9,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk_sys,   // System clock.
    input  wire logic             reset_n,   // Asynchronous reset, active low.
    input  wire logic             clk_en,    // Freezes all state while low.
    input  wire logic             in_valid,  // Write request.
    output logic                  in_ready,  // Space available.
    input  wire logic [WIDTH-1:0] in_data,   // Write word.
    output logic                  out_valid, // Word available.
    input  wire logic             out_ready, // Read request.
    output logic      [WIDTH-1:0] out_data   // Read word.
);
    localparam int unsigned PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0]      wr_q;
    logic [PW:0]      rd_q;
    logic             push;
    logic             pop;

    // The extra pointer bit tells a full FIFO from an empty one.
    assign in_ready  = (wr_q[PW] == rd_q[PW]) || (wr_q[PW-1:0] != rd_q[PW-1:0]);
    assign out_valid = (wr_q != rd_q);
    assign out_data  = mem[rd_q[PW-1:0]];
    assign push      = clk_en && in_valid && in_ready;
    assign pop       = clk_en && out_valid && out_ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_q[PW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wr_q <= '0;
        end else if (push) begin
            wr_q <= wr_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rd_q <= '0;
        end else if (pop) begin
            rd_q <= rd_q + 1'b1;
        end
    end
endmodule

module hdla_arbiter
    import hdla_pkg::*;
#(
    parameter int unsigned UNIT_CYC = UNIT_CYCLES
) (
    input  wire logic              clk_sys,         // System clock, 10 MHz.
    input  wire logic              reset_n,         // Asynchronous reset, active low.
    input  wire logic              clk_en,          // Freezes all state while low.
    input  wire logic              cfg_half_duplex, // Select half-duplex operation.
    input  wire logic              cfg_priority,    // Own sending wins a collision.
    input  wire logic              cfg_resend_all,  // Resume from the message start.
    input  wire logic              cfg_dtr_dsr,     // DTR/DSR flow control on.
    input  wire logic [WAIT_W-1:0] cfg_wait_units,  // Resume wait in units.
    input  wire logic              dc_flow_req,     // Software asks for DC1/DC3 control.
    output logic                   dc_flow_allowed, // DC1/DC3 control may run.
    input  wire logic [DATA_W-1:0] in_data,         // Byte to send.
    input  wire logic              in_last,         // Byte ends a message.
    input  wire logic              in_valid,        // Byte offered.
    output logic                   in_ready,        // Byte taken.
    output logic      [DATA_W-1:0] ser_data,        // Byte to the serializer.
    output logic                   ser_valid,       // Byte offered to the serializer.
    input  wire logic              ser_ready,       // Serializer takes the byte.
    input  wire logic              ser_idle,        // Serializer line is quiet.
    input  wire logic              rx_room,         // Receiver can accept data.
    input  wire logic              cd_pin,          // Carrier-detect pin.
    input  wire logic              dsr_pin,         // Data-set-ready pin.
    output logic                   rts_pin,         // Request-to-send pin.
    output logic                   dtr_pin,         // Data-terminal-ready pin.
    output logic                   busy,            // A message is in progress.
    output logic                   collision        // One-cycle pulse on an abort.
);
    hdla_word_t       fifo_in;
    hdla_word_t       fifo_out;
    logic             fifo_valid;
    logic             fifo_ready;
    hdla_state_t      state_q;
    hdla_cfg_t        cfg_q;
    logic [1:0]       cd_sync_q;
    logic [1:0]       dsr_sync_q;
    logic             cd_s;
    logic             dsr_s;
    logic [DATA_W-1:0] msg_mem [MSG_DEPTH];
    logic [LEN_W-1:0] len_q;
    logic [IDX_W-1:0] idx_q;
    logic [IDX_W-1:0] last_sent_q;
    logic             rts_q;
    logic [WAIT_W-1:0] units_q;
    logic [UNIT_CNT_W-1:0] tick_q;
    logic             flow_ok;
    logic             abort;
    logic             take;
    logic             load;
    logic             msg_end;

    function automatic logic [WAIT_W-1:0] clamp_wait(input logic [WAIT_W-1:0] w);
        clamp_wait = (w == WAIT_ZERO) ? WAIT_MIN : w;
    endfunction

    // In full duplex the carrier never holds the port back.
    function automatic logic line_clear(input logic half_duplex, input logic carrier);
        line_clear = !half_duplex || !carrier;
    endfunction

    assign fifo_in = '{last: in_last, data: in_data};

    hdla_fifo #(
        .WIDTH ($bits(hdla_word_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .clk_en    (clk_en),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .in_data   (fifo_in),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready),
        .out_data  (fifo_out)
    );

    // Both pins come from the far device and are never looked at before the second stage.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cd_sync_q  <= 2'h0;
            dsr_sync_q <= 2'h0;
        end else if (clk_en) begin
            cd_sync_q  <= {cd_sync_q[0], cd_pin};
            dsr_sync_q <= {dsr_sync_q[0], dsr_pin};
        end
    end
    assign cd_s  = cd_sync_q[1];
    assign dsr_s = dsr_sync_q[1];

    // Settings are taken only between messages so a change never splits one.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cfg_q <= CFG_RESET; // RQ16
        end else if (clk_en && state_q == ST_IDLE) begin
            cfg_q <= '{cfg_half_duplex, cfg_priority, cfg_resend_all, cfg_dtr_dsr,
                       clamp_wait(cfg_wait_units)};
        end
    end

    assign flow_ok   = !cfg_q.dtr_dsr_on || dsr_s; // RQ12
    assign abort     = cfg_q.half_duplex && !cfg_q.priority_on && cd_s
                       && (state_q == ST_SEND || state_q == ST_DRAIN); // RQ6 RQ9
    assign ser_valid = (state_q == ST_SEND) && flow_ok && !abort; // RQ12
    assign ser_data  = msg_mem[idx_q];
    assign take      = clk_en && ser_valid && ser_ready;
    assign fifo_ready = (state_q == ST_LOAD);
    assign load      = clk_en && fifo_ready && fifo_valid;
    assign msg_end   = fifo_out.last || (len_q == LEN_MAX - LEN_ONE);
    assign dc_flow_allowed = dc_flow_req && !cfg_q.half_duplex; // RQ14
    assign dtr_pin   = !cfg_q.dtr_dsr_on || rx_room;
    assign rts_pin   = rts_q;
    assign busy      = (state_q != ST_IDLE);
    assign collision = clk_en && abort;

    always_ff @(posedge clk_sys) begin
        if (load) begin
            msg_mem[len_q[IDX_W-1:0]] <= fifo_out.data;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            len_q <= LEN_ZERO;
        end else if (clk_en) begin
            if (state_q == ST_IDLE) begin
                len_q <= LEN_ZERO;
            end else if (load) begin
                len_q <= len_q + LEN_ONE;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
        end else if (clk_en) begin
            unique case (state_q)
                ST_IDLE: begin
                    if (fifo_valid) begin
                        state_q <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    if (load && msg_end) begin
                        state_q <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    if (line_clear(cfg_q.half_duplex, cd_s)) begin
                        state_q <= ST_RTS; // RQ1 RQ5
                    end
                end
                ST_RTS: begin
                    state_q <= ST_SEND; // RQ5
                end
                ST_SEND: begin
                    if (abort) begin
                        state_q <= ST_HOLD; // RQ9
                    end else if (take && idx_q == len_q[IDX_W-1:0] - IDX_ONE) begin
                        state_q <= ST_DRAIN;
                    end
                end
                ST_DRAIN: begin
                    if (abort) begin
                        state_q <= ST_HOLD; // RQ9
                    end else if (ser_idle) begin
                        state_q <= ST_IDLE; // RQ2
                    end
                end
                ST_HOLD: begin
                    if (!cd_s) begin
                        state_q <= ST_GAP; // RQ11
                    end
                end
                ST_GAP: begin
                    // A carrier that returns during the wait starts the wait over.
                    if (cd_s) begin
                        state_q <= ST_HOLD;
                    end else if (units_q == WAIT_ZERO) begin
                        state_q <= ST_CHECK; // RQ15
                    end
                end
            endcase
        end
    end

    // Request-to-send rises one cycle before the first byte is offered.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rts_q <= 1'b0;
        end else if (clk_en) begin
            if (state_q == ST_CHECK && line_clear(cfg_q.half_duplex, cd_s)) begin
                rts_q <= 1'b1; // RQ2 RQ5
            end else if (abort || (state_q == ST_DRAIN && ser_idle)) begin
                rts_q <= 1'b0; // RQ2 RQ9
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            idx_q <= IDX_ZERO;
        end else if (clk_en) begin
            if (state_q == ST_LOAD) begin
                idx_q <= IDX_ZERO;
            end else if (abort) begin
                // The byte in the serializer may be cut short, so it is sent again.
                idx_q <= cfg_q.resend_all ? IDX_ZERO : last_sent_q; // RQ11
            end else if (take) begin
                idx_q <= idx_q + IDX_ONE; // RQ12
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            last_sent_q <= IDX_ZERO;
        end else if (clk_en) begin
            if (state_q == ST_LOAD) begin
                last_sent_q <= IDX_ZERO;
            end else if (take) begin
                last_sent_q <= idx_q;
            end
        end
    end

    // The wait counts whole units; the unit length is a parameter so tests can shorten it.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            units_q <= WAIT_ZERO;
            tick_q  <= '0;
        end else if (clk_en) begin
            if (state_q != ST_GAP) begin
                units_q <= cfg_q.wait_units; // RQ15
                tick_q  <= UNIT_CNT_W'(UNIT_CYC - 1);
            end else if (tick_q == '0) begin
                units_q <= units_q - WAIT_MIN;
                tick_q  <= UNIT_CNT_W'(UNIT_CYC - 1);
            end else begin
                tick_q <= tick_q - 1'b1;
            end
        end
    end
endmodule

// file: hdla_pkg.sv
// Notes on behaviour
// RQ1 - In half-duplex operation the port never starts sending while carrier-detect shows a reception.
// RQ2 - Request-to-send is high while the port transmits and drops once the transmission is over.
// RQ3 - The far device raises carrier-detect only while request-to-send is low, else it waits.
// RQ4 - The far device sends only after raising carrier-detect and drops it when its message ends.
// RQ5 - The port raises request-to-send only with carrier-detect low and sends only after that; in full duplex the code raises it whatever carrier-detect shows.
// RQ6 - In priority mode a carrier-detect rise during sending does not stop the message.
// RQ7 - In priority mode the far device aborts its own message when request-to-send rises.
// RQ8 - In priority mode the far device resends its aborted message once the port has finished.
// RQ9 - In nonpriority mode a carrier-detect rise during sending aborts the message and drops RTS.
// RQ10 - In nonpriority mode the far device may finish its message although RTS rose meanwhile.
// RQ11 - In nonpriority mode the aborted message resumes from the start or from the last data sent.
// RQ12 - With DTR/DSR control on, sending pauses while DSR is low and resumes at the paused data.
// RQ13 - With DTR/DSR control on, the far device pauses while DTR is low and resumes afterwards.
// RQ14 - DC1/DC3 software flow control is refused while the port is in half-duplex operation.
// RQ15 - In nonpriority mode a programmed wait of 1 to 255 units precedes the resumed sending.
// RQ16 - After reset the port works full duplex until half-duplex operation is selected.
package hdla_pkg;

    localparam int unsigned DATA_W        = 8;
    localparam int unsigned FIFO_DEPTH    = 8;
    localparam int unsigned MSG_DEPTH     = 16;
    localparam int unsigned IDX_W         = 4;
    localparam int unsigned LEN_W         = 5;
    localparam int unsigned WAIT_W        = 8;
    localparam int unsigned UNIT_CNT_W    = 24;

    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned WAIT_UNIT_MS  = 10;
    localparam int unsigned UNIT_CYCLES   = WAIT_UNIT_MS * 1000000 / CLK_PERIOD_NS;

    localparam logic [IDX_W-1:0]  IDX_ZERO = 4'h0;
    localparam logic [IDX_W-1:0]  IDX_ONE  = 4'h1;
    localparam logic [LEN_W-1:0]  LEN_ZERO = 5'h00;
    localparam logic [LEN_W-1:0]  LEN_ONE  = 5'h01;
    localparam logic [LEN_W-1:0]  LEN_MAX  = 5'h10;
    localparam logic [WAIT_W-1:0] WAIT_MIN = 8'h01;
    localparam logic [WAIT_W-1:0] WAIT_ZERO = 8'h00;

    typedef struct packed {
        logic              last;
        logic [DATA_W-1:0] data;
    } hdla_word_t;

    typedef struct packed {
        logic              half_duplex;
        logic              priority_on;
        logic              resend_all;
        logic              dtr_dsr_on;
        logic [WAIT_W-1:0] wait_units;
    } hdla_cfg_t;

    localparam hdla_cfg_t CFG_RESET = '{1'b0, 1'b1, 1'b0, 1'b0, 8'h01};

    typedef enum logic [7:0] {
        ST_IDLE  = 8'b0000_0001,
        ST_LOAD  = 8'b0000_0010,
        ST_CHECK = 8'b0000_0100,
        ST_RTS   = 8'b0000_1000,
        ST_SEND  = 8'b0001_0000,
        ST_DRAIN = 8'b0010_0000,
        ST_HOLD  = 8'b0100_0000,
        ST_GAP   = 8'b1000_0000
    } hdla_state_t;

endpackage

// file: hdla_arbiter_properties.sv
`timescale 1ns/100ps

module hdla_arbiter_checker
    import hdla_pkg::*;
(
    input wire logic clk_sys,         // System clock.
    input wire logic reset_n,         // Reset, active low.
    input wire logic clk_en,          // Clock enable.
    input wire logic cfg_half_duplex, // Half duplex.
    input wire logic cfg_priority,    // Priority mode.
    input wire logic cfg_dtr_dsr,     // DTR/DSR control.
    input wire logic dc_flow_req,     // DC1/DC3 request.
    input wire logic dc_flow_allowed, // DC1/DC3 grant.
    input wire logic ser_valid,       // Byte offered.
    input wire logic rx_room,         // Receiver room.
    input wire logic cd_pin,          // Carrier detect.
    input wire logic dsr_pin,         // Data set ready.
    input wire logic rts_pin,         // Request to send.
    input wire logic dtr_pin,         // Data terminal ready.
    input wire logic busy,            // Message in progress.
    input wire logic collision        // Abort pulse.
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // Two idle edges guarantee that the port levels have been latched.
    sequence s_idle_hd;
        (cfg_half_duplex && !busy && clk_en)[*2];
    endsequence
    sequence s_idle_fd;
        (!cfg_half_duplex && !busy && clk_en)[*2];
    endsequence
    sequence s_idle_dd;
        (cfg_dtr_dsr && !busy && clk_en)[*2];
    endsequence

    a_send_needs_rts: assert property (ser_valid |-> rts_pin) else $error("send without rts");
    a_rts_idle_low: assert property ((!busy)[*2] |-> !rts_pin) else $error("rts while idle");
    a_rts_waits_cd: assert property ($rose(rts_pin) && cfg_half_duplex |->
        !($past(cd_pin, 2) && $past(cd_pin, 3) && $past(cd_pin, 4))) else $error("rts over cd");
    a_priority_no_abort: assert property (cfg_priority |-> !collision) else $error("prio abort");
    a_abort_drops_rts: assert property (collision |-> cfg_half_duplex && !ser_valid ##1 !rts_pin)
        else $error("abort left rts");
    a_dc_gate_hd: assert property (s_idle_hd |=> !dc_flow_allowed) else $error("dc in half");
    a_dc_pass_fd: assert property (s_idle_fd |=> dc_flow_allowed == dc_flow_req)
        else $error("dc in full");
    a_dtr_follows_room: assert property (s_idle_dd |=> dtr_pin == rx_room) else $error("dtr");
    a_dsr_pauses: assert property ((cfg_dtr_dsr && !dsr_pin)[*4] |-> !ser_valid)
        else $error("send with dsr low");
endmodule

bind hdla_arbiter hdla_arbiter_checker hdla_arbiter_checker_inst (.clk_sys, .reset_n, .clk_en,
    .cfg_half_duplex, .cfg_priority, .cfg_dtr_dsr, .dc_flow_req, .dc_flow_allowed, .ser_valid,
    .rx_room, .cd_pin, .dsr_pin, .rts_pin, .dtr_pin, .busy, .collision);

// file: hdla_far_model.sv
`timescale 1ns/100ps

module hdla_far_model (
    input  wire logic clk_sys,   // System clock.
    input  wire logic reset_n,   // Reset, active low.
    input  wire logic rts_pin,   // Request to send from the port.
    input  wire logic dtr_pin,   // Receive permission from the port.
    input  wire logic ser_valid, // Byte offered to the serializer.
    input  wire logic far_go,    // Far side has a message.
    input  wire logic rude,      // Far side ignores rts on purpose.
    output logic      ser_ready, // Serializer takes a byte.
    output logic      ser_idle,  // Serializer line quiet.
    output logic      cd_pin     // Carrier detect toward the port.
);
    logic [3:0] byte_q;
    logic [3:0] msg_q;

    // A byte occupies the line for six cycles, so the port sees real stalls.
    assign ser_ready = (byte_q == 4'h0);
    assign ser_idle  = (byte_q == 4'h0);

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            byte_q <= 4'h0;
        end else if (ser_valid && ser_ready) begin
            byte_q <= 4'h6;
        end else if (byte_q != 4'h0) begin
            byte_q <= byte_q - 4'h1;
        end
    end

    // A held far_go retries after rts drops, resending the whole message.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cd_pin <= 1'b0;
            msg_q  <= 4'h0;
        end else if (!cd_pin) begin
            if (far_go && (!rts_pin || rude)) begin
                cd_pin <= 1'b1;
                msg_q  <= 4'hf;
            end
        end else if (msg_q == 4'h0 || (rts_pin && !rude)) begin
            cd_pin <= 1'b0;
        end else if (dtr_pin) begin
            msg_q <= msg_q - 4'h1;
        end
    end
endmodule

// file: testbench.sv
`timescale 1ns/100ps

module testbench;
    import hdla_pkg::*;
    localparam int UNIT_TB = 4;
    typedef logic [7:0] hdla_bq_t[$];
    logic clk_sys = 0, reset_n = 0, clk_en = 1, hd = 0, prio = 1, rall = 0, dd = 0, dcr = 1;
    logic in_last = 0, in_valid = 0, rx = 1, dsr = 1, far_go = 0, rude = 0;
    logic [7:0] in_data = 8'h00, ser_data, wu = 8'h03;
    logic dca, in_ready, ser_valid, ser_ready, ser_idle, cd_pin, rts_pin, dtr_pin, busy, collision;
    int error_cnt = 0, checks_done = 0, cyc = 0, coll_n = 0;
    hdla_bq_t got;

    always #50 clk_sys = ~clk_sys;

    hdla_arbiter #(.UNIT_CYC(UNIT_TB)) hdla_arbiter_inst (.clk_sys, .reset_n, .clk_en,
        .cfg_half_duplex(hd), .cfg_priority(prio), .cfg_resend_all(rall), .cfg_dtr_dsr(dd),
        .cfg_wait_units(wu), .dc_flow_req(dcr), .dc_flow_allowed(dca), .in_data, .in_last,
        .in_valid, .in_ready, .ser_data, .ser_valid, .ser_ready, .ser_idle, .rx_room(rx), .cd_pin,
        .dsr_pin(dsr), .rts_pin, .dtr_pin, .busy, .collision);
    hdla_far_model hdla_far_model_inst (.clk_sys, .reset_n, .rts_pin, .dtr_pin, .ser_valid,
        .far_go, .rude, .ser_ready, .ser_idle, .cd_pin);

    always @(posedge clk_sys) begin
        cyc++;
        if (ser_valid === 1'b1 && ser_ready === 1'b1) got.push_back(ser_data);
        if (collision === 1'b1) coll_n++;
        if (cyc == 5000) begin
            error_cnt++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic hdla_bq_t ramp(input logic [7:0] b, input int n);
        ramp = {};
        for (int i = 0; i < n; i++) ramp.push_back(8'(b + i));
    endfunction

    // With keep set, in_valid stays high so the next message follows without a gap.
    task automatic msg(input logic [7:0] b, input int n, input bit keep = 1'b0);
        for (int i = 0; i < n; i++) begin
            in_data = 8'(b + i);
            in_last = (i == n - 1);
            in_valid = 1'b1;
            while (in_ready !== 1'b1) @(negedge clk_sys);
            @(negedge clk_sys);
        end
        if (!keep) in_valid = 1'b0;
    endtask

    task automatic wait_for(input int n, input logic v);
        int k;
        for (k = 0; k < 200 && (n > 0 ? got.size() < n : cd_pin !== v); k++) @(negedge clk_sys);
        chk(k < 200, 1'b1);
    endtask

    task automatic fin(input hdla_bq_t e);
        for (int k = 0; k < 3000 && !(busy === 1'b0 && got.size() >= e.size()); k++)
            @(negedge clk_sys);
        chk(8'(got.size()), 8'(e.size()));
        foreach (e[i]) chk(got[i], e[i]);
        chk(rts_pin, 1'b0);
        chk(busy, 1'b0);
        got = {};
    endtask

    task automatic t_reset();
        chk({rts_pin, busy, in_ready, dtr_pin}, 8'h03);
        chk(dca, 1'b1);
    endtask

    task automatic t_full();
        far_go = 1;
        rude = 1;
        wait_for(0, 1'b1);
        far_go = 0;
        msg(8'h20, 2);
        fin(ramp(8'h20, 2));
        wait_for(0, 1'b0);
        rude = 0;
    endtask

    task automatic t_fill();
        hd = 1;
        @(negedge clk_sys);
        far_go = 1;
        wait_for(0, 1'b1);
        far_go = 0;
        repeat (3) @(negedge clk_sys);
        msg(8'h10, 1, 1'b1);
        msg(8'h11, 8);
        chk(in_ready, 1'b0);
        chk(rts_pin, 1'b0);
        chk(dca, 1'b0);
        fin(ramp(8'h10, 9));
    endtask

    task automatic t_prio();
        coll_n = 0;
        msg(8'h30, 4);
        wait_for(1, 1'b0);
        far_go = 1;
        rude = 1;
        wait_for(0, 1'b1);
        far_go = 0;
        fin(ramp(8'h30, 4));
        chk(8'(coll_n), 8'h00);
        wait_for(0, 1'b0);
        rude = 0;
    endtask

    task automatic t_np(input logic r);
        int n;
        prio = 0;
        rall = r;
        wu = r ? 8'h01 : 8'h03;
        coll_n = 0;
        @(negedge clk_sys);
        msg(8'h40, 4);
        wait_for(2, 1'b0);
        far_go = 1;
        rude = 1;
        wait_for(0, 1'b1);
        far_go = 0;
        wait_for(0, 1'b0);
        rude = 0;
        for (n = 0; n < 200 && rts_pin !== 1'b1; n++) @(negedge clk_sys);
        chk(n >= UNIT_TB * wu, 1'b1);
        chk(n <= (UNIT_TB + 1) * wu + 8, 1'b1);
        chk(coll_n > 0, 1'b1);
        fin({ramp(8'h40, 2), ramp(r ? 8'h40 : 8'h41, r ? 4 : 3)});
    endtask

    task automatic t_dsr();
        hd = 0;
        dd = 1;
        rx = 0;
        @(negedge clk_sys);
        @(negedge clk_sys);
        chk(dtr_pin, 1'b0);
        msg(8'h50, 3);
        wait_for(1, 1'b0);
        dsr = 0;
        repeat (20) @(negedge clk_sys);
        chk(8'(got.size()), 8'h01);
        dsr = 1;
        rx = 1;
        fin(ramp(8'h50, 3));
    endtask

    initial begin
        repeat (10) @(negedge clk_sys);
        reset_n = 1;
        t_reset();
        t_full();
        t_fill();
        t_prio();
        t_np(1'b0);
        t_np(1'b1);
        t_dsr();
        conclude();
    end
endmodule
